// ==== src/asss_params.svh ====
// Constants of the angle sensor serial slave port
`ifndef ASSS_PARAMS_SVH
`define ASSS_PARAMS_SVH

// ==========================================================
// Frame layout
`define ASSS_BIT_PARITY    15
`define ASSS_BIT_RW        14
`define ASSS_BIT_ERR_IND   14
`define ASSS_LAST_EDGE     5'h0F

// ==========================================================
// Register addresses
`define ASSS_ADDR_NOP      14'h0000
`define ASSS_ADDR_ERRLAT   14'h0001
`define ASSS_ADDR_PROG     14'h0003
`define ASSS_ADDR_ZPOS_HI  14'h0016
`define ASSS_ADDR_ZPOS_LO  14'h0017
`define ASSS_ADDR_SET1     14'h0018
`define ASSS_ADDR_SET2     14'h0019
`define ASSS_ADDR_REDUN    14'h001A
`define ASSS_ADDR_DIAG     14'h3FFC
`define ASSS_ADDR_MAGN     14'h3FFD
`define ASSS_ADDR_ANG_RAW  14'h3FFE
`define ASSS_ADDR_ANG_CMP  14'h3FFF

// ==========================================================
// Reset values
`define ASSS_IDX_SET1      3
`define ASSS_RST_SET1      14'h0001
`define ASSS_RST_ZERO      14'h0000

// ==========================================================
// Timing
`define ASSS_PON_MS        10
`define ASSS_MCLK_KHZ      100000
`define ASSS_PON_CYCLES    (`ASSS_PON_MS * `ASSS_MCLK_KHZ)

`endif

// ==== src/asss_pkg.sv ====
// Types of the angle sensor serial slave port
package asss_pkg;

  // Transaction phase
  typedef enum logic [0:0] {
    ASSS_WAIT_CMD  = 1'b0,
    ASSS_WAIT_DATA = 1'b1
  } asss_state_t;

  // Frame as seen on MOSI or MISO
  typedef struct packed {
    logic        parity;
    logic        flag;
    logic [13:0] data;
  } asss_word_t;

  // Measurement words handed in by the sensor core
  typedef struct packed {
    logic [13:0] diag;
    logic [13:0] magn;
    logic [13:0] ang_raw;
    logic [13:0] ang_cmp;
  } asss_sensor_t;

  // Error latch, bit 2 down to bit 0
  typedef struct packed {
    logic parity_error_flag;
    logic bad_address_flag;
    logic framing_error_flag;
  } asss_err_t;

endpackage : asss_pkg

// ==== src/asss_spi_slave.sv ====
// Serial slave port of the angle sensor with its register file
`timescale 1ns/1ps
`include "asss_params.svh"

module asss_spi_slave
  import asss_pkg::*;
#(
  parameter int PON_CYCLES = `ASSS_PON_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire asss_sensor_t      sensor,
  input  wire logic              sclk,
  input  wire logic              chip_select_n,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   miso_oe,
  output logic                   ready,
  output asss_err_t              err_flags,
  output logic [5:0][13:0]       soft_regs
);

  // ========================================================
  // Link side, on the master's serial clock, 10 MHz max
  // Sclk and select are only read here, never driven

  logic        link_rst_reg;
  logic [4:0]  rx_cnt_reg;
  logic [15:0] rx_shift_reg;
  logic        len_ok_reg;
  logic        start_tgl_reg;
  logic [3:0]  tx_idx_reg;
  logic        miso_reg;
  logic        miso_oe_reg;
  asss_word_t  resp_reg;

  // Reset for link flops, taken from the system clock
  always_ff @(posedge mclk) begin
    link_rst_reg <= !rst_n;
  end

  // Falling-edge count, held clear while select is high
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n)
      rx_cnt_reg <= 5'h00;
    else if (rx_cnt_reg != 5'h1F)
      rx_cnt_reg <= rx_cnt_reg + 5'h01;
  end

  // MOSI sampled on falling edge, MSB first
  always_ff @(negedge sclk) begin
    rx_shift_reg <= {rx_shift_reg[14:0], mosi};
    len_ok_reg   <= (rx_cnt_reg == `ASSS_LAST_EDGE);
  end

  // Toggles on first edge so an empty frame is seen
  always_ff @(negedge sclk or posedge link_rst_reg) begin
    if (link_rst_reg)
      start_tgl_reg <= 1'b0;
    else if (rx_cnt_reg == 5'h00)
      start_tgl_reg <= !start_tgl_reg;
  end

  // Bit pointer and output enable, dropped by select
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_idx_reg  <= 4'hF;
      miso_oe_reg <= 1'b0;
    end else begin
      tx_idx_reg  <= tx_idx_reg - 4'h1;
      miso_oe_reg <= 1'b1;
    end
  end

  // Launch on rising edge so the master samples on falling.
  // Resp is only rewritten after select rises, so it is
  // quiet for the whole next frame and may be read here.
  always_ff @(posedge sclk or posedge link_rst_reg) begin
    if (link_rst_reg)
      miso_reg <= 1'b0;
    else
      miso_reg <= resp_reg[tx_idx_reg];
  end

  assign miso    = miso_reg;
  assign miso_oe = miso_oe_reg;

  // ========================================================
  // Crossing into the system clock

  logic [1:0]  cs_sync_reg;
  logic [1:0]  tgl_sync_reg;
  logic [1:0]  len_sync_reg;
  logic [15:0] rx_sync1_reg;
  logic [15:0] rx_sync2_reg;
  logic        cs_last_reg;
  logic        tgl_seen_reg;

  // Two stages for every level from the link side
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_sync_reg  <= 2'b11;
      tgl_sync_reg <= 2'b00;
      len_sync_reg <= 2'b00;
      rx_sync1_reg <= 16'h0000;
      rx_sync2_reg <= 16'h0000;
      cs_last_reg  <= 1'b1;
    end else if (ce) begin
      cs_sync_reg  <= {cs_sync_reg[0], chip_select_n};
      tgl_sync_reg <= {tgl_sync_reg[0], start_tgl_reg};
      len_sync_reg <= {len_sync_reg[0], len_ok_reg};
      rx_sync1_reg <= rx_shift_reg;
      rx_sync2_reg <= rx_sync1_reg;
      cs_last_reg  <= cs_sync_reg[1];
    end
  end

  // ========================================================
  // Frame decode

  logic       frame_end;
  logic       frame_ok;
  logic       par_ok;
  asss_word_t rx_word;

  assign rx_word   = rx_sync2_reg;
  // Execute only once select has risen
  assign frame_end = ce && cs_sync_reg[1] && !cs_last_reg;
  // Edges seen and exactly sixteen of them
  assign frame_ok  = (tgl_sync_reg[1] != tgl_seen_reg)
                     && len_sync_reg[1];
  // Even parity over all sixteen bits
  assign par_ok    = ~^rx_sync2_reg;

  // Soft register index from an address
  logic       soft_hit;
  logic [2:0] soft_idx;

  always_comb begin
    soft_hit = 1'b1;
    soft_idx = 3'h0;
    case (rx_word.data)
      `ASSS_ADDR_PROG:    soft_idx = 3'h0;
      `ASSS_ADDR_ZPOS_HI: soft_idx = 3'h1;
      `ASSS_ADDR_ZPOS_LO: soft_idx = 3'h2;
      `ASSS_ADDR_SET1:    soft_idx = 3'h3;
      `ASSS_ADDR_SET2:    soft_idx = 3'h4;
      `ASSS_ADDR_REDUN:   soft_idx = 3'h5;
      default:            soft_hit = 1'b0;
    endcase
  end

  // Read multiplexer; measurements read zero until ready
  logic [13:0]  rd_data;
  logic         rd_hit;
  logic [13:0]  soft_reg [6];
  asss_err_t    err_reg;
  logic         ready_reg;
  asss_sensor_t meas;

  assign meas = ready_reg ? sensor : '0;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 14'h0000;
    if (soft_hit) begin
      rd_data = soft_reg[soft_idx];
    end else begin
      case (rx_word.data)
        `ASSS_ADDR_NOP:     rd_data = 14'h0000;
        `ASSS_ADDR_ERRLAT:  rd_data = {11'h000, err_reg};
        `ASSS_ADDR_DIAG:    rd_data = meas.diag;
        `ASSS_ADDR_MAGN:    rd_data = meas.magn;
        `ASSS_ADDR_ANG_RAW: rd_data = meas.ang_raw;
        `ASSS_ADDR_ANG_CMP: rd_data = meas.ang_cmp;
        default:            rd_hit  = 1'b0;
      endcase
    end
  end

  // ========================================================
  // Transaction control

  asss_state_t state_reg;
  asss_state_t state_next;
  logic        pend_hit_reg;
  logic [2:0]  pend_idx_reg;
  logic        bad_frame;
  logic        par_bad;
  logic        cmd_go;
  logic        data_go;
  logic        addr_bad;
  logic        err_clear;
  logic        do_write;
  logic        is_read;

  assign is_read   = rx_word.flag;
  assign bad_frame = frame_end && !frame_ok;
  assign par_bad   = frame_end && frame_ok && !par_ok;
  assign cmd_go    = frame_end && frame_ok && par_ok
                     && (state_reg == ASSS_WAIT_CMD);
  assign data_go   = frame_end && frame_ok && par_ok
                     && (state_reg == ASSS_WAIT_DATA);
  assign addr_bad  = cmd_go && !rd_hit;
  assign err_clear = cmd_go && is_read
                     && (rx_word.data == `ASSS_ADDR_ERRLAT);
  assign do_write  = data_go && pend_hit_reg;

  // Phase: a write command expects one data frame
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ASSS_WAIT_CMD: begin
        if (cmd_go && !is_read)
          state_next = ASSS_WAIT_DATA;
      end
      ASSS_WAIT_DATA: begin
        if (frame_end)
          state_next = ASSS_WAIT_CMD;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      state_reg <= ASSS_WAIT_CMD;
    else
      state_reg <= state_next;
  end

  // Remember target of a write and mark frames consumed
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_hit_reg <= 1'b0;
      pend_idx_reg <= 3'h0;
      tgl_seen_reg <= 1'b0;
    end else if (frame_end) begin
      tgl_seen_reg <= tgl_sync_reg[1];
      if (cmd_go) begin
        pend_hit_reg <= soft_hit;
        pend_idx_reg <= soft_idx;
      end
    end
  end

  // Soft registers, one per entry
  for (genvar i = 0; i < 6; i++) begin : g_soft
    always_ff @(posedge mclk) begin
      if (!rst_n)
        soft_reg[i] <= (i == `ASSS_IDX_SET1) ? `ASSS_RST_SET1
                                             : `ASSS_RST_ZERO;
      else if (do_write && pend_idx_reg == 3'(i))
        soft_reg[i] <= rx_word.data;
    end
    assign soft_regs[i] = soft_reg[i];
  end

  // Error latch: new events win over the read clear
  always_ff @(posedge mclk) begin
    if (!rst_n)
      err_reg <= '0;
    else if (ce)
      err_reg <= (err_clear ? '0 : err_reg)
                 | {par_bad, addr_bad, bad_frame};
  end

  assign err_flags = err_reg;

  // Answer for the next frame, parity made even
  logic [13:0] resp_data;
  logic        resp_err;

  always_comb begin
    resp_data = 14'h0000;
    if (cmd_go && rd_hit)
      resp_data = rd_data;
    else if (do_write)
      resp_data = rx_word.data;
  end

  assign resp_err = bad_frame || par_bad || addr_bad;

  always_ff @(posedge mclk) begin
    if (!rst_n)
      resp_reg <= '0;
    else if (frame_end)
      resp_reg <= {^{resp_err, resp_data}, resp_err, resp_data};
  end

  // ========================================================
  // Power-on wait; counted in system clocks
  logic [19:0] pon_cnt_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pon_cnt_reg <= 20'h00000;
      ready_reg   <= 1'b0;
    end else if (ce && !ready_reg) begin
      if (pon_cnt_reg == 20'(PON_CYCLES - 1))
        ready_reg <= 1'b1;
      else
        pon_cnt_reg <= pon_cnt_reg + 20'h00001;
    end
  end

  assign ready = ready_reg;

  // ========================================================
  // Checks

  sequence frame_bad_s;
    frame_end && !frame_ok;
  endsequence

  sequence write_cmd_s;
    cmd_go && !is_read && soft_hit;
  endsequence

  framing_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_bad_s |=> err_reg.framing_error_flag && resp_reg.flag)
    else $error("framing error not flagged");

  frame_reject_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_bad_s |-> !do_write ##1 state_reg == ASSS_WAIT_CMD)
    else $error("bad frame was executed");

  parity_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    par_bad |=> err_reg.parity_error_flag && resp_reg.flag)
    else $error("parity error not flagged");

  bad_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    addr_bad |=> err_reg.bad_address_flag)
    else $error("bad address not flagged");

  err_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    err_clear |=> err_reg == '0 && resp_reg.data[2:0] == $past(err_reg))
    else $error("error latch not returned and cleared");

  resp_parity_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end |=> ~^resp_reg)
    else $error("answer parity odd");

  clean_ind_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_go && rd_hit |=> !resp_reg.flag && resp_reg.data == $past(rd_data))
    else $error("read answer wrong");

  old_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    write_cmd_s |=> resp_reg.data == $past(rd_data)
      && state_reg == ASSS_WAIT_DATA)
    else $error("old content not returned");

  write_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    do_write |=> soft_reg[pend_idx_reg] == resp_reg.data)
    else $error("write not loaded or echoed");

  exec_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg != $past(state_reg) |-> $past(frame_end))
    else $error("command run outside frame end");

  pon_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !ready_reg && cmd_go && is_read
      && rx_word.data == `ASSS_ADDR_ANG_CMP |=> resp_reg.data == 14'h0000)
    else $error("data given before power-on time");

  miso_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_sync_reg[1] && cs_last_reg |-> !miso_oe_reg)
    else $error("MISO driven while deselected");

endmodule : asss_spi_slave

// ==== tb/asss_spi_host.sv ====
// Serial master model that drives frames into the slave port
`timescale 1ns/1ps

module asss_spi_host (
  output logic     sclk,
  output logic     chip_select_n,
  output logic     mosi,
  input  wire logic miso
);
  logic lclk;

  // ==========================================================
  // Link clock, 30 ns, phase unrelated to mclk
  initial begin
    lclk = 1'b0;
    #7.3;
    forever #15 lclk = ~lclk;
  end

  // Idle state: clock still and low, select high
  initial begin
    sclk          = 1'b0;
    chip_select_n = 1'b1;
    mosi          = 1'b0;
  end

  // ==========================================================
  // One frame; half period of two link cycles keeps sclk below 10 MHz
  task automatic xfer(input logic [15:0] tx, input int nclk,
                      output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge lclk) chip_select_n <= 1'b0;
    repeat (12) @(posedge lclk); // Lead time over 350 ns
    for (int i = 0; i < nclk; i++) begin
      sclk <= 1'b1;
      mosi <= tx[15 - i];
      repeat (2) @(posedge lclk);
      sclk <= 1'b0;
      rx = {rx[14:0], miso};
      repeat (2) @(posedge lclk);
    end
    chip_select_n <= 1'b1;
    mosi          <= ~mosi; // Released line must not hold a stale level
    repeat (12) @(posedge lclk); // Gap over 350 ns for the crossing
  endtask : xfer
endmodule : asss_spi_host

// ==== tb/asss_spi_slave_test.sv ====
// Self-checking bench of the angle sensor serial slave port
`timescale 1ns/1ps

module asss_spi_slave_test;
  import asss_pkg::*;
  localparam int PON = 400; // One frame ends before ready, two after

  logic             mclk;
  logic             rst_n;
  logic             ce;
  logic             sclk;
  logic             chip_select_n;
  logic             mosi;
  logic             miso;
  logic             miso_oe;
  logic             ready;
  asss_sensor_t     sensor;
  asss_err_t        err_flags;
  logic [5:0][13:0] soft_regs;
  int               bad_count;
  int               samples_checked;

  // ==========================================================
  // Clock and instances
  always #5 mclk = ~mclk;

  asss_spi_slave #(.PON_CYCLES(PON)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .sensor(sensor), .sclk(sclk),
    .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .ready(ready), .err_flags(err_flags),
    .soft_regs(soft_regs)
  );

  asss_spi_host u_host (
    .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso)
  );

  // ==========================================================
  // Helpers
  // Even parity in bit 15 over the lower fifteen bits
  function automatic logic [15:0] mk(input logic [14:0] w);
    return {^w, w};
  endfunction : mk

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Full frame, answer compared, line released afterwards
  task automatic frame(input logic [15:0] tx, input logic [15:0] exp);
    logic [15:0] rx;
    u_host.xfer(tx, 16, rx);
    chk("miso word", exp, rx);
    chk("miso_oe idle", 16'h0000, {15'h0000, miso_oe});
  endtask : frame

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    chk("soft reg 0x18", 16'h0001, {2'b00, soft_regs[3]});
    chk("soft reg 0x03", 16'h0000, {2'b00, soft_regs[0]});
    chk("flags", 16'h0000, {13'h0000, err_flags});
    chk("ready early", 16'h0000, {15'h0000, ready});
    // Angle read before ready must come back as zero
    frame(mk(15'h7FFF), 16'h0000);
    chk("ready mid", 16'h0000, {15'h0000, ready});
    frame(mk(15'h4000), 16'h0000);
    chk("ready", 16'h0001, {15'h0000, ready});
  endtask : test_reset

  task automatic test_read;
    frame(mk(15'h7FFF), 16'h0000);
    frame(mk(15'h4000), mk({1'b0, 14'h2A5C}));
  endtask : test_read

  task automatic test_write;
    frame(mk(15'h0018), 16'h0000);
    frame(mk(15'h0005), mk(15'h0001));
    chk("soft reg 0x18", 16'h0005, {2'b00, soft_regs[3]});
    frame(mk(15'h4000), mk(15'h0005));
  endtask : test_write

  task automatic test_parity;
    frame(mk(15'h7FFF) ^ 16'h8000, 16'h0000);
    chk("parity flag", 16'h0004, {13'h0000, err_flags});
    frame(mk(15'h4000), mk(15'h4000));
  endtask : test_parity

  task automatic test_bad_address;
    frame(mk(15'h4100), 16'h0000);
    chk("address flag", 16'h0006, {13'h0000, err_flags});
    frame(mk(15'h4000), mk(15'h4000));
  endtask : test_bad_address

  task automatic test_framing_latch;
    logic [15:0] rx;
    u_host.xfer(mk(15'h4000), 8, rx);
    chk("short frame answer", 16'h0000, rx);
    chk("framing flag", 16'h0007, {13'h0000, err_flags});
    frame(mk(15'h4001), mk(15'h4000));
    chk("flags cleared", 16'h0000, {13'h0000, err_flags});
    frame(mk(15'h4000), mk(15'h0007));
  endtask : test_framing_latch

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    mclk            = 1'b0;
    rst_n           = 1'b0;
    ce              = 1'b1;
    sensor          = '0;
    sensor.ang_cmp  = 14'h2A5C;
    bad_count       = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    chk("miso_oe reset", 16'h0000, {15'h0000, miso_oe});
    rst_n <= 1'b1;
    @(posedge mclk);
    test_reset();
    test_read();
    test_write();
    test_parity();
    test_bad_address();
    test_framing_latch();
    end_sim();
  end

  // Frames take about 3 us each; far more than enough margin
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule : asss_spi_slave_test
